// [include/pmil_pkg.sv]
package pmil_pkg;
    // management register addresses
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_LP_ABILITY = 5'h05;
    localparam logic [4:0] REG_AN_EXP = 5'h06;
    localparam logic [4:0] REG_MODE_CS = 5'h11;
    localparam logic [4:0] REG_FLAGS = 5'h1d;
    localparam logic [4:0] REG_MASK = 5'h1e;
    localparam logic [4:0] UNSUP_LO = 5'h07;
    localparam logic [4:0] UNSUP_HI = 5'h0f;
    localparam logic [15:0] READ_UNSUP = 16'hffff;
    // source / flag / mask bit positions
    localparam int SRC_RENEG = 0;
    localparam int SRC_PAGE = 1;
    localparam int SRC_PDF = 2;
    localparam int SRC_ACK = 3;
    localparam int SRC_LINK = 4;
    localparam int SRC_RFLT = 5;
    localparam int SRC_ANC = 6;
    localparam int SRC_ENERGY = 7;
    // status field positions inside the status registers
    localparam int ST_ANC_POS = 5;
    localparam int ST_RFLT_POS = 4;
    localparam int ST_LINK_POS = 2;
    localparam int ST_ACK_POS = 14;
    localparam int ST_PDF_POS = 4;
    localparam int ST_PAGE_POS = 1;
    localparam int ST_ENERGY_POS = 1;
    localparam int MODE_ALT_POS = 6;
    // flag groups
    localparam logic [7:0] FLAG_BITS = 8'hfe;
    localparam logic [7:0] RISE_SRCS = 8'hee;
    localparam logic [7:0] LINK_BIT = 8'h10;
    localparam logic [7:0] REG1_CLR = 8'h30;
    localparam logic [7:0] REG6_CLR = 8'h06;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h80;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic ALT_RST = 1'b0;
    localparam logic [7:0] SRC_RST = 8'h80;
    localparam logic [4:0] PHY_ADDR_DEF = 5'h00;
    // frame layout
    localparam logic [5:0] PRE_LEN = 6'd32;
    localparam logic [1:0] OP_RD = 2'b10;
    localparam logic [1:0] OP_WR = 2'b01;
    // timing
    localparam int CLK_HZ = 50000000;
    localparam int LATE_DELAY_MS = 1000;
    localparam int LATE_PULSE_MS = 256;
    localparam int LATE_DELAY_CYC = CLK_HZ / 1000 * LATE_DELAY_MS;
    localparam int LATE_PULSE_CYC = CLK_HZ / 1000 * LATE_PULSE_MS;
    localparam int TMR_W = 26;

    typedef enum logic [2:0] {
        S_PRE = 3'b000,
        S_ST = 3'b001,
        S_HDR = 3'b010,
        S_TA = 3'b011,
        S_DATA = 3'b100
    } pmil_smi_state_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_WAIT = 2'b01,
        T_PULSE = 2'b10
    } pmil_tmr_state_t;
endpackage

// [include/pmil_link_if.sv]
`timescale 1ns/1ps
interface pmil_link_if;
    logic [7:0] level;
    logic [7:0] rise;
    logic [7:0] fall;
    logic arm;
    logic cancel;
    logic late_active;
    modport sync_mp(output level, output rise, output fall);
    modport timer_mp(input arm, input cancel, output late_active);
    modport core_mp(input level, input rise, input fall,
        output arm, output cancel, input late_active);
endinterface

// [rtl/pmil_sync_edge.sv]
`timescale 1ns/1ps
module pmil_sync_edge (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] raw,
    pmil_link_if.sync_mp lnk
);
    import pmil_pkg::*;

    logic [7:0] stage1;
    logic [7:0] stage2;
    logic [7:0] prev;
    logic [7:0] next_stage1;
    logic [7:0] next_stage2;
    logic [7:0] next_prev;

    // energy starts high so acquisition start gives no false edge
    always_comb begin
        next_stage1 = raw;
        next_stage2 = stage1;
        next_prev = stage2;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1 <= SRC_RST;
            stage2 <= SRC_RST;
            prev <= SRC_RST;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            prev <= next_prev;
        end
    end

    // edges from registered stages only, one pulse per change
    assign lnk.level = stage2;
    assign lnk.rise = stage2 & ~prev;
    assign lnk.fall = ~stage2 & prev;
endmodule

// [rtl/pmil_late_timer.sv]
`timescale 1ns/1ps
module pmil_late_timer #(
    parameter int DELAY_CYC = pmil_pkg::LATE_DELAY_CYC,
    parameter int PULSE_CYC = pmil_pkg::LATE_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    pmil_link_if.timer_mp lnk
);
    import pmil_pkg::*;

    pmil_tmr_state_t state;
    pmil_tmr_state_t next_state;
    logic [TMR_W-1:0] cnt;
    logic [TMR_W-1:0] next_cnt;

    // wait about a second after energy loss, then hold for the pulse
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            T_IDLE: begin
                if (lnk.arm && !lnk.cancel) begin
                    next_state = T_WAIT;
                    next_cnt = TMR_W'(DELAY_CYC - 1);
                end
            end
            T_WAIT: begin
                if (lnk.cancel) begin
                    next_state = T_IDLE;
                end else if (cnt == '0) begin
                    next_state = T_PULSE;
                    next_cnt = TMR_W'(PULSE_CYC - 1);
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            T_PULSE: begin
                if (lnk.cancel || cnt == '0) begin
                    next_state = T_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: next_state = T_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= T_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign lnk.late_active = (state == T_PULSE);

    property p_arm_waits;
        @(posedge clk) disable iff (!rst_b)
        (state == T_IDLE && lnk.arm && !lnk.cancel) |=> state == T_WAIT;
    endproperty
    a_arm_waits: assert property (p_arm_waits)
        else $error("late energy timer did not start");
endmodule

// [rtl/pmil_top.sv]
// Operation
// - irq_n_out low while an enabled event pends
// - only masked-in sources assert; modes differ releasing
// - reset selects primary mode, mode bit zero
// - writing mode bit one selects alternate mode
// - mask and flag bits 7..1 map sources
// - rising source edges set flags; link falls
// - primary: source fall (link excepted) or register reads release
// - alternate: clearing mask bit releases output
// - alternate: write one clears flag if condition
// - condition: source low; link down needs link up
// - primary: read-released energy irq reasserts 1000 ms after energy loss, for 256 ms
// - energy flag reads one after power-up
// - registers 7 to 15 read as ffff
`timescale 1ns/1ps
module pmil_top #(
    parameter int LATE_DELAY_CYC = pmil_pkg::LATE_DELAY_CYC,
    parameter int LATE_PULSE_CYC = pmil_pkg::LATE_PULSE_CYC,
    parameter logic [4:0] PHY_ADDR = pmil_pkg::PHY_ADDR_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic line_energy_detect,
    input wire logic an_complete,
    input wire logic remote_fault,
    input wire logic link_status,
    input wire logic partner_ack,
    input wire logic par_det_fault,
    input wire logic page_received,
    input wire logic renegotiate,
    output logic irq_n_out
);
    import pmil_pkg::*;

    pmil_link_if lnk();

    pmil_sync_edge u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .raw({line_energy_detect, an_complete, remote_fault, link_status,
            partner_ack, par_det_fault, page_received, renegotiate}),
        .lnk(lnk.sync_mp)
    );

    pmil_late_timer #(
        .DELAY_CYC(LATE_DELAY_CYC),
        .PULSE_CYC(LATE_PULSE_CYC)
    ) u_late (
        .clk(clk),
        .rst_b(rst_b),
        .lnk(lnk.timer_mp)
    );

    // read value of an address, taken before any read side effect
    function automatic logic [15:0] reg_read(input logic [4:0] addr,
        input logic [7:0] flg, input logic [7:0] msk, input logic alt,
        input logic [7:0] lvl);
        logic [15:0] v;
        v = 16'h0000;
        if (addr >= UNSUP_LO && addr <= UNSUP_HI) begin
            v = READ_UNSUP;
        end else if (addr == REG_FLAGS) begin
            v = {8'h00, flg & FLAG_BITS};
        end else if (addr == REG_MASK) begin
            v = {8'h00, msk & FLAG_BITS};
        end else if (addr == REG_MODE_CS) begin
            v[MODE_ALT_POS] = alt;
            v[ST_ENERGY_POS] = lvl[SRC_ENERGY];
        end else if (addr == REG_STATUS) begin
            v[ST_ANC_POS] = lvl[SRC_ANC];
            v[ST_RFLT_POS] = lvl[SRC_RFLT];
            v[ST_LINK_POS] = lvl[SRC_LINK];
        end else if (addr == REG_LP_ABILITY) begin
            v[ST_ACK_POS] = lvl[SRC_ACK];
        end else if (addr == REG_AN_EXP) begin
            v[ST_PDF_POS] = lvl[SRC_PDF];
            v[ST_PAGE_POS] = lvl[SRC_PAGE];
        end
        return v;
    endfunction

    // management pins: two flops before use, third only for the edge
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_s3 <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdc_s1 <= mdc;
            mdc_s2 <= mdc_s1;
            mdc_s3 <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end
    end

    logic mdc_rise;
    logic sbit;
    assign mdc_rise = mdc_s2 & ~mdc_s3;
    assign sbit = mdio_s2;

    // frame engine state
    pmil_smi_state_t state;
    pmil_smi_state_t next_state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [11:0] hdr;
    logic [11:0] next_hdr;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic next_mdio_out;
    logic next_mdio_oe;
    logic rd_fire;
    logic wr_fire;
    logic [15:0] wr_word;

    // register state
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic alt_irq_mode_sel;
    logic next_alt;
    logic pending;
    logic next_pending;
    logic next_irq_n;
    logic [7:0] clr;
    logic [7:0] set;
    logic [7:0] cond_ok;
    logic irq_any;

    // serial frame: preamble, start, op, address, turnaround, data
    always_comb begin
        logic [11:0] hdr_n;
        hdr_n = {hdr[10:0], sbit};
        next_state = state;
        next_cnt = cnt;
        next_hdr = hdr;
        next_shreg = shreg;
        next_mdio_out = mdio_out;
        next_mdio_oe = mdio_oe;
        rd_fire = 1'b0;
        wr_fire = 1'b0;
        wr_word = {shreg[14:0], sbit};
        if (mdc_rise) begin
            case (state)
                S_PRE: begin
                    if (sbit) begin
                        if (cnt < PRE_LEN) next_cnt = cnt + 1'b1;
                    end else if (cnt >= PRE_LEN) begin
                        next_state = S_ST;
                    end else begin
                        next_cnt = '0;
                    end
                end
                S_ST: begin
                    next_cnt = '0;
                    next_state = sbit ? S_HDR : S_PRE;
                end
                S_HDR: begin
                    next_hdr = hdr_n;
                    next_cnt = cnt + 1'b1;
                    if (cnt == 6'd11) begin
                        next_cnt = '0;
                        next_state = S_PRE;
                        // a foreign address leaves the pin alone
                        if (hdr_n[9:5] == PHY_ADDR) begin
                            if (hdr_n[11:10] == OP_RD) begin
                                rd_fire = 1'b1;
                                next_shreg = reg_read(hdr_n[4:0], flags,
                                    mask, alt_irq_mode_sel, lnk.level);
                                next_state = S_TA;
                            end else if (hdr_n[11:10] == OP_WR) begin
                                next_state = S_TA;
                            end
                        end
                    end
                end
                S_TA: begin
                    if (hdr[11:10] == OP_RD) begin
                        next_mdio_oe = 1'b1;
                        next_mdio_out = 1'b0;
                        next_state = S_DATA;
                    end else if (cnt == 6'd1) begin
                        next_cnt = '0;
                        next_state = S_DATA;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                S_DATA: begin
                    next_cnt = cnt + 1'b1;
                    if (hdr[11:10] == OP_RD) begin
                        if (cnt == 6'd16) begin
                            next_mdio_oe = 1'b0;
                            next_mdio_out = 1'b0;
                            next_cnt = '0;
                            next_state = S_PRE;
                        end else begin
                            next_mdio_out = shreg[15];
                            next_shreg = {shreg[14:0], 1'b0};
                        end
                    end else begin
                        next_shreg = wr_word;
                        if (cnt == 6'd15) begin
                            wr_fire = 1'b1;
                            next_cnt = '0;
                            next_state = S_PRE;
                        end
                    end
                end
                default: begin
                    next_cnt = '0;
                    next_state = S_PRE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= S_PRE;
            cnt <= '0;
            hdr <= '0;
            shreg <= '0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            hdr <= next_hdr;
            shreg <= next_shreg;
            mdio_out <= next_mdio_out;
            mdio_oe <= next_mdio_oe;
        end
    end

    // flags, mask, mode and the late energy assertion
    always_comb begin
        set = (lnk.rise & RISE_SRCS) | (lnk.fall & LINK_BIT);
        cond_ok = ~lnk.level ^ LINK_BIT;
        clr = 8'h00;
        if (!alt_irq_mode_sel) begin
            clr = lnk.fall & RISE_SRCS;
            if (rd_fire && hdr_n_addr_is(REG_FLAGS)) clr = clr | FLAG_BITS;
            if (rd_fire && hdr_n_addr_is(REG_STATUS)) clr = clr | REG1_CLR;
            if ((rd_fire && hdr_n_addr_is(REG_AN_EXP)) ||
                lnk.rise[SRC_RENEG] || lnk.fall[SRC_LINK]) begin
                clr = clr | REG6_CLR;
            end
        end else if (wr_fire && hdr[4:0] == REG_FLAGS) begin
            clr = wr_word[7:0] & cond_ok & FLAG_BITS;
        end
        // a new edge wins over a clear in the same cycle
        next_flags = ((flags & ~clr) | set) & FLAG_BITS;
        next_mask = mask;
        next_alt = alt_irq_mode_sel;
        if (wr_fire && hdr[4:0] == REG_MASK) begin
            next_mask = wr_word[7:0] & FLAG_BITS;
        end
        if (wr_fire && hdr[4:0] == REG_MODE_CS) begin
            next_alt = wr_word[MODE_ALT_POS];
        end
        next_pending = pending;
        if (clr[SRC_ENERGY] && flags[SRC_ENERGY] && !set[SRC_ENERGY] &&
            lnk.level[SRC_ENERGY] && mask[SRC_ENERGY]) begin
            next_pending = 1'b1;
        end
        if (lnk.fall[SRC_ENERGY] || !mask[SRC_ENERGY]) next_pending = 1'b0;
        // masked sources only, the timer overrides flags
        next_irq_n = ~irq_any;
    end

    // the read address is the header just completed
    function automatic logic hdr_n_addr_is(input logic [4:0] a);
        return {hdr[3:0], sbit} == a;
    endfunction

    assign irq_any = |(flags & mask) | lnk.late_active;
    assign lnk.arm = pending & lnk.fall[SRC_ENERGY];
    // software clearing the mask is the documented way to avoid it
    assign lnk.cancel = ~mask[SRC_ENERGY] | lnk.rise[SRC_ENERGY];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags <= FLAGS_RST;
            mask <= MASK_RST;
            alt_irq_mode_sel <= ALT_RST;
            pending <= 1'b0;
            irq_n_out <= 1'b1;
        end else begin
            flags <= next_flags;
            mask <= next_mask;
            alt_irq_mode_sel <= next_alt;
            pending <= next_pending;
            irq_n_out <= next_irq_n;
        end
    end

    property p_irq_follows;
        @(posedge clk) disable iff (!rst_b)
        irq_any |=> !irq_n_out;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq_n_out not asserted for pending event");

    property p_masked_quiet;
        @(posedge clk) disable iff (!rst_b)
        (mask == 8'h00 && !lnk.late_active) |=> irq_n_out;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("irq_n_out asserted with all sources masked");

    property p_reset_primary;
        @(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |-> !alt_irq_mode_sel && flags[SRC_ENERGY];
    endproperty
    a_reset_primary: assert property (p_reset_primary)
        else $error("reset did not give primary mode and energy flag");

    property p_alt_write;
        @(posedge clk) disable iff (!rst_b)
        (wr_fire && hdr[4:0] == REG_MODE_CS && wr_word[MODE_ALT_POS])
            |=> alt_irq_mode_sel ##1 alt_irq_mode_sel;
    endproperty
    a_alt_write: assert property (p_alt_write)
        else $error("mode write did not select alternate mode");

    property p_rise_sets;
        @(posedge clk) disable iff (!rst_b)
        lnk.rise[SRC_ANC] |=> flags[SRC_ANC] ##1 !irq_n_out || !mask[SRC_ANC];
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising source edge lost");

    property p_read_clears;
        @(posedge clk) disable iff (!rst_b)
        (!alt_irq_mode_sel && rd_fire && hdr_n_addr_is(REG_FLAGS) &&
            set == 8'h00) |=> flags == 8'h00;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flag read did not clear flags in primary mode");

    property p_alt_keep;
        @(posedge clk) disable iff (!rst_b)
        (alt_irq_mode_sel && flags[SRC_RFLT] && lnk.level[SRC_RFLT])
            |=> flags[SRC_RFLT];
    endproperty
    a_alt_keep: assert property (p_alt_keep)
        else $error("flag cleared while its source still high");

    property p_link_cond;
        @(posedge clk) disable iff (!rst_b)
        (alt_irq_mode_sel && wr_fire && hdr[4:0] == REG_FLAGS &&
            wr_word[SRC_LINK] && lnk.level[SRC_LINK] && !lnk.fall[SRC_LINK])
            |=> !flags[SRC_LINK];
    endproperty
    a_link_cond: assert property (p_link_cond)
        else $error("link down flag not cleared with link up");

    property p_unsup_ffff;
        @(posedge clk) disable iff (!rst_b)
        (rd_fire && {hdr[3:0], sbit} >= UNSUP_LO &&
            {hdr[3:0], sbit} <= UNSUP_HI) |=> shreg == READ_UNSUP;
    endproperty
    a_unsup_ffff: assert property (p_unsup_ffff)
        else $error("unsupported register did not read ffff");
endmodule

// [verif/pmil_smc_model.sv]
`timescale 1ns/1ps
module pmil_smc_model (
    input wire logic clk,
    input wire logic mdio,
    output logic mdc,
    output logic drv,
    output logic drv_oe
);
    import pmil_pkg::*;
    // mdc half period in clocks, well above the three-clock floor
    localparam int HALF = 10;
    // mdc parks low between frames; line released to the pull-up
    initial begin
        mdc = 1'b0;
        drv = 1'b1;
        drv_oe = 1'b0;
    end
    // one mdc period; data moves only while mdc is low
    task automatic bit_cyc(input logic d, output logic s);
        drv = d;
        repeat (HALF) @(negedge clk);
        mdc = 1'b1;
        repeat (HALF) @(negedge clk);
        s = mdio;
        mdc = 1'b0;
    endtask
    // whole frame with full preamble; reads sample late in the high phase
    task automatic frame(input logic [1:0] op, input logic [4:0] ra,
            input logic [15:0] wd, output logic [15:0] rd);
        logic s;
        logic [13:0] hdr;
        logic [17:0] wbits;
        hdr = {2'b01, op, PHY_ADDR_DEF, ra};
        wbits = {2'b10, wd};
        rd = 16'h0000;
        drv_oe = 1'b1;
        repeat (32) bit_cyc(1'b1, s);
        for (int i = 13; i >= 0; i--)
            bit_cyc(hdr[i], s);
        if (op == OP_RD) begin
            drv_oe = 1'b0;
            bit_cyc(1'b1, s);
            for (int i = 15; i >= 0; i--) begin
                bit_cyc(1'b1, s);
                rd[i] = s;
            end
            bit_cyc(1'b1, s);
        end else begin
            for (int i = 17; i >= 0; i--)
                bit_cyc(wbits[i], s);
            drv_oe = 1'b0;
        end
    endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import pmil_pkg::*;
    // short late-pulse counts keep the run brief
    localparam int DLY = 40;
    localparam int PLS = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] src = 8'h90;
    logic mdc, drv, drv_oe, mdio_out, mdio_oe, irq_n_out, mdio;
    int mismatches = 0;
    int n_checks = 0;

    // pull-up wins when nobody drives
    assign mdio = mdio_oe ? mdio_out : (drv_oe ? drv : 1'b1);
    always #10 clk = ~clk;

    pmil_top #(.LATE_DELAY_CYC(DLY), .LATE_PULSE_CYC(PLS)) pmil_top_i (
        .clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .line_energy_detect(src[SRC_ENERGY]), .an_complete(src[SRC_ANC]),
        .remote_fault(src[SRC_RFLT]), .link_status(src[SRC_LINK]),
        .partner_ack(src[SRC_ACK]), .par_det_fault(src[SRC_PDF]),
        .page_received(src[SRC_PAGE]), .renegotiate(src[SRC_RENEG]),
        .irq_n_out(irq_n_out));
    pmil_smc_model pmil_smc_model_i (.clk(clk), .mdio(mdio), .mdc(mdc),
        .drv(drv), .drv_oe(drv_oe));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk16(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // register access over the management frames
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] v;
        pmil_smc_model_i.frame(OP_RD, ra, 16'h0000, v);
        chk16("mdio read data", exp, v);
        chk1("mdio_oe after frame", 1'b0, mdio_oe);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] v;
        pmil_smc_model_i.frame(OP_WR, ra, wd, v);
    endtask
    // bounded wait; a hang ends the run at once
    task automatic wait_irq(input logic lvl, input int n);
        int k;
        k = 0;
        while (irq_n_out !== lvl && k < n) begin
            @(negedge clk);
            k++;
        end
        chk1("irq_n_out", lvl, irq_n_out);
        if (irq_n_out !== lvl)
            stop_test();
    endtask
    task automatic hold_irq(input logic lvl);
        repeat (10) @(negedge clk);
        chk1("irq_n_out level", lvl, irq_n_out);
    endtask

    // main sequence: reset state, primary mode, then alternate mode
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        hold_irq(1'b1);
        rd(REG_FLAGS, 16'h0080);
        rd(REG_FLAGS, 16'h0000);
        rd(REG_MODE_CS, 16'h0002);
        rd(5'h08, READ_UNSUP);
        rd(REG_MASK, 16'h0000);
        src[SRC_ENERGY] = 1'b0;
        wr(REG_MASK, 16'h00fe);
        // each flag source, bits 1 to 7, in turn; energy last arms the late pulse
        for (int i = 1; i < 8; i++) begin
            src[i] = ~src[i];
            wait_irq(1'b0, 20);
            rd(REG_FLAGS, 16'h0001 << i);
            hold_irq(1'b1);
            src[i] = ~src[i];
            hold_irq(1'b1);
        end
        wait_irq(1'b0, DLY + 60);
        wait_irq(1'b1, PLS + 10);
        wr(REG_MASK, 16'h0000);
        src[SRC_PAGE] = 1'b1;
        hold_irq(1'b1);
        rd(REG_FLAGS, 16'h0002);
        src[SRC_PAGE] = 1'b0;
        wr(REG_MASK, 16'h0002);
        src[SRC_PAGE] = 1'b1;
        wait_irq(1'b0, 20);
        src[SRC_RENEG] = 1'b1;
        wait_irq(1'b1, 20);
        src[SRC_PAGE] = 1'b0;
        src[SRC_RENEG] = 1'b0;
        wr(REG_MODE_CS, 16'h0040);
        rd(REG_MODE_CS, 16'h0040);
        wr(REG_MASK, 16'h0020);
        src[SRC_RFLT] = 1'b1;
        wait_irq(1'b0, 20);
        rd(REG_FLAGS, 16'h0020);
        wr(REG_FLAGS, 16'h0020);
        hold_irq(1'b0);
        src[SRC_RFLT] = 1'b0;
        hold_irq(1'b0);
        wr(REG_FLAGS, 16'h0020);
        hold_irq(1'b1);
        rd(REG_FLAGS, 16'h0000);
        src[SRC_RFLT] = 1'b1;
        wait_irq(1'b0, 20);
        wr(REG_MASK, 16'h0000);
        hold_irq(1'b1);
        // link down clears only once the link is back up
        wr(REG_MASK, 16'h0010);
        src[SRC_LINK] = 1'b0;
        wait_irq(1'b0, 20);
        wr(REG_FLAGS, 16'h0010);
        hold_irq(1'b0);
        src[SRC_LINK] = 1'b1;
        wr(REG_FLAGS, 16'h0010);
        hold_irq(1'b1);
        stop_test();
    end
endmodule
